// ===== logic/wfh_pkg.sv
// Purpose: shared constants and types for the wake and fault handshake
// Assumes: 20 MHz clock, 50 ns period
// Notes: times kept in their own units, cycle counts derived
package wfh_pkg;
  localparam int CLK_KHZ = 20000;
  localparam int RETRY_US = 5000;
  localparam int CLEAR_OC_US = 85;
  localparam int CLEAR_TSD_US = 4200;
  localparam int DEGLITCH_NS = 2000;
  localparam int RETRY_CYC = RETRY_US * CLK_KHZ / 1000;
  localparam int CLEAR_OC_CYC = (CLEAR_OC_US * CLK_KHZ + 999) / 1000;
  localparam int CLEAR_TSD_CYC = (CLEAR_TSD_US * CLK_KHZ + 999) / 1000;
  localparam int DEGLITCH_CYC = (DEGLITCH_NS * CLK_KHZ / 1000 + 999) / 1000;
  localparam int PULSE_CYC = 4;
  // sleep entry: pin low longer than any reset pulse
  localparam int SLEEP_CYC = 16;
  localparam int CNT_W = 20;
  localparam logic [1:0] VAR_HW = 2'h0;
  localparam logic [1:0] VAR_SPI_INT = 2'h1;
  localparam logic [1:0] VAR_SPI_EXT = 2'h2;
  typedef enum logic [4:0] {
    ST_SLEEP = 5'h01,
    ST_ACK_WAIT = 5'h02,
    ST_STANDBY = 5'h04,
    ST_FAULT_OFF = 5'h08,
    ST_RETRY_ON = 5'h10
  } wfh_state_t;
endpackage : wfh_pkg

// ===== logic/wfh_link_if.sv
// Purpose: link between driver device and controller
// Assumes: fault flag pin open drain, pulled up outside
// Notes: wire level resolved here from the enable
`timescale 1ns/1ps
interface wfh_link_if;
  logic sleep_control_pin;
  logic clear_fault_command;
  logic fault_flag_pin_oe;
  logic fault_flag_pin_o;
  logic fault_flag_pin;
  assign fault_flag_pin = fault_flag_pin_oe ? fault_flag_pin_o : 1'b1;
  modport device (input sleep_control_pin, input clear_fault_command, input fault_flag_pin,
    output fault_flag_pin_oe, output fault_flag_pin_o);
  modport ctrl (output sleep_control_pin, output clear_fault_command, input fault_flag_pin);
endinterface : wfh_link_if

// ===== logic/wfh_timer.sv
// Purpose: restartable interval counter
// Assumes: limit at least 1
// Notes: done is a level while run stays high after the limit
`timescale 1ns/1ps
module wfh_timer (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic [19:0] i_limit,
  output logic o_done
);
  logic [19:0] cnt_ff;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= 20'h00000;
    end else if (!i_run) begin
      cnt_ff <= 20'h00000;
    end else if (cnt_ff != i_limit) begin
      cnt_ff <= cnt_ff + 20'h00001;
    end
  end
  assign o_done = i_run && (cnt_ff == i_limit);
endmodule : wfh_timer

// ===== logic/wfh_device.sv
// Purpose: device end of the wake and fault handshake
// Assumes: fault detectors and supply monitors are async levels
// Notes: retry or latch reaction chosen by a strap input
//
// Contract
// - sleep pin high wakes device
// - fault flag low after wake registered
// - internal supply undervoltage holds reset
// - external-supply variant uses logic supply
// - hardwired controller acknowledges with sleep pulse
// - serial controller acknowledges with clear command
// - acknowledgment releases flag, enters standby
// - persistent overcurrent disables output, flags
// - retry re-enables output after interval
// - retry repeats until disabled or cleared
// - flag stays low across retries
// - fault-free retry keeps output enabled
// - flag released after full clear interval
// - thermal retry waits for cool-down
// - serial fault status latched until clear
// - latch mode waits for controller clear
// - persistent fault detected again after clear
// - sense pin held at limit on short
// - retry interval five milliseconds
// - overcurrent clear interval 85 us
// - thermal clear interval 4.2 ms
`timescale 1ns/1ps
module wfh_device (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [1:0] i_variant,
  input wire logic i_latch_mode,
  input wire logic i_regulator_uv,
  input wire logic i_logic_supply_uv,
  input wire logic i_overcurrent,
  input wire logic i_hs_short_gnd,
  input wire logic i_over_temp,
  input wire logic i_driver_enable,
  wfh_link_if.device link,
  output logic o_output_enable,
  output logic o_sense_at_limit,
  output logic o_status_overcurrent,
  output logic o_status_thermal,
  output logic o_in_standby
);
  logic [1:0] s_sleep_ff, s_oc_ff, s_ot_ff, s_uv_ff, s_uv2_ff, s_gnd_ff, s_clr_ff;
  logic sleep_q, oc_q, ot_q, gnd_q, clr_q, sleep_prev_ff, por_q;
  logic serial_v, ack_pulse, deglitch_done, retry_done, clear_done, ot_was_ff;
  logic run_deg, run_retry, run_clear;
  logic run_sleep, sleep_done;
  logic fault_low_ff, clearing_ff, oe_ff, limit_ff, st_oc_ff, st_ot_ff, stby_ff;
  wfh_pkg::wfh_state_t state_ff, nxt_state;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_sleep_ff <= 2'h0;
      s_oc_ff <= 2'h0;
      s_ot_ff <= 2'h0;
      s_uv_ff <= 2'h3;
      s_uv2_ff <= 2'h3;
      s_gnd_ff <= 2'h0;
      s_clr_ff <= 2'h0;
    end else begin
      s_sleep_ff <= {s_sleep_ff[0], link.sleep_control_pin};
      s_oc_ff <= {s_oc_ff[0], i_overcurrent};
      s_ot_ff <= {s_ot_ff[0], i_over_temp};
      s_uv_ff <= {s_uv_ff[0], i_regulator_uv};
      s_uv2_ff <= {s_uv2_ff[0], i_logic_supply_uv};
      s_gnd_ff <= {s_gnd_ff[0], i_hs_short_gnd};
      s_clr_ff <= {s_clr_ff[0], link.clear_fault_command};
    end
  end
  assign sleep_q = s_sleep_ff[1];
  assign oc_q = s_oc_ff[1];
  assign ot_q = s_ot_ff[1];
  assign gnd_q = s_gnd_ff[1];
  assign clr_q = s_clr_ff[1];
  assign serial_v = (i_variant != wfh_pkg::VAR_HW);
  // supply reset source depends on variant
  assign por_q = (i_variant == wfh_pkg::VAR_SPI_EXT) ? s_uv2_ff[1] : s_uv_ff[1];

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sleep_prev_ff <= 1'b0;
    end else begin
      sleep_prev_ff <= sleep_q;
    end
  end
  // controller acknowledgment: clear command or sleep reset pulse end
  assign ack_pulse = serial_v ? clr_q : (sleep_q && !sleep_prev_ff);

  // long low on the sleep pin means sleep; a reset pulse stays shorter
  assign run_sleep = !sleep_q && (i_variant != wfh_pkg::VAR_SPI_EXT) &&
    (state_ff != wfh_pkg::ST_SLEEP);
  wfh_timer u_sleep (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_run(run_sleep),
    .i_limit(20'(wfh_pkg::SLEEP_CYC)),
    .o_done(sleep_done)
  );

  assign run_deg = oc_q && (state_ff == wfh_pkg::ST_STANDBY || state_ff == wfh_pkg::ST_RETRY_ON);
  assign run_retry = (state_ff == wfh_pkg::ST_FAULT_OFF) && !i_latch_mode && !ot_was_ff;
  assign run_clear = clearing_ff && !oc_q && !ot_q;

  wfh_timer u_deg (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_run(run_deg),
    .i_limit(20'(wfh_pkg::DEGLITCH_CYC)), .o_done(deglitch_done));
  wfh_timer u_retry (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_run(run_retry),
    .i_limit(20'(wfh_pkg::RETRY_CYC)), .o_done(retry_done));
  wfh_timer u_clear (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_run(run_clear),
    .i_limit(ot_was_ff ? 20'(wfh_pkg::CLEAR_TSD_CYC) : 20'(wfh_pkg::CLEAR_OC_CYC)),
    .o_done(clear_done));

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      wfh_pkg::ST_SLEEP: if (sleep_q) nxt_state = wfh_pkg::ST_ACK_WAIT;
      wfh_pkg::ST_ACK_WAIT: if (ack_pulse) nxt_state = wfh_pkg::ST_STANDBY;
      wfh_pkg::ST_STANDBY, wfh_pkg::ST_RETRY_ON: begin
        if (deglitch_done || ot_q) nxt_state = wfh_pkg::ST_FAULT_OFF;
        else if (!i_driver_enable) nxt_state = wfh_pkg::ST_STANDBY;
      end
      wfh_pkg::ST_FAULT_OFF: begin
        if (!i_driver_enable && !i_latch_mode) nxt_state = wfh_pkg::ST_STANDBY;
        else if (i_latch_mode && ack_pulse) nxt_state = wfh_pkg::ST_STANDBY;
        else if (!i_latch_mode && retry_done) nxt_state = wfh_pkg::ST_RETRY_ON;
        else if (!i_latch_mode && ot_was_ff && !ot_q) nxt_state = wfh_pkg::ST_RETRY_ON;
      end
      default: nxt_state = wfh_pkg::ST_SLEEP;
    endcase
    if (sleep_done) nxt_state = wfh_pkg::ST_SLEEP;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= wfh_pkg::ST_SLEEP;
    end else if (por_q) begin
      // recovery with the sleep pin high, or with no sleep pin, acts as a wake
      if (sleep_q || i_variant == wfh_pkg::VAR_SPI_EXT) begin
        state_ff <= wfh_pkg::ST_ACK_WAIT;
      end else begin
        state_ff <= wfh_pkg::ST_SLEEP;
      end
    end else begin
      state_ff <= nxt_state;
    end
  end

  // fault flag low from wake until ack, during faults, and until clear interval ends
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_low_ff <= 1'b0;
      clearing_ff <= 1'b0;
      ot_was_ff <= 1'b0;
    end else if (por_q) begin
      fault_low_ff <= 1'b0;
      clearing_ff <= 1'b0;
      ot_was_ff <= 1'b0;
    end else if (nxt_state == wfh_pkg::ST_SLEEP) begin
      fault_low_ff <= 1'b0;
      clearing_ff <= 1'b0;
      ot_was_ff <= 1'b0;
    end else if (nxt_state == wfh_pkg::ST_ACK_WAIT) begin
      fault_low_ff <= 1'b1;
    end else if (nxt_state == wfh_pkg::ST_FAULT_OFF) begin
      fault_low_ff <= 1'b1;
      clearing_ff <= 1'b0;
      if (state_ff != wfh_pkg::ST_FAULT_OFF) ot_was_ff <= ot_q;
    end else if (state_ff == wfh_pkg::ST_FAULT_OFF && nxt_state == wfh_pkg::ST_RETRY_ON) begin
      clearing_ff <= 1'b1;
    end else if (state_ff == wfh_pkg::ST_FAULT_OFF || state_ff == wfh_pkg::ST_ACK_WAIT) begin
      fault_low_ff <= 1'b0;
      clearing_ff <= 1'b0;
    end else if (clear_done) begin
      fault_low_ff <= 1'b0;
      clearing_ff <= 1'b0;
      ot_was_ff <= 1'b0;
    end
  end

  // serial status bits: set wins over clear
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_oc_ff <= 1'b0;
      st_ot_ff <= 1'b0;
    end else begin
      st_oc_ff <= (deglitch_done && serial_v) || (st_oc_ff && !clr_q);
      st_ot_ff <= (ot_q && serial_v) || (st_ot_ff && !clr_q);
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oe_ff <= 1'b0;
      limit_ff <= 1'b0;
      stby_ff <= 1'b0;
    end else begin
      oe_ff <= i_driver_enable && !por_q &&
        (nxt_state == wfh_pkg::ST_STANDBY || nxt_state == wfh_pkg::ST_RETRY_ON);
      limit_ff <= (nxt_state == wfh_pkg::ST_FAULT_OFF) && (gnd_q || (limit_ff && !por_q));
      stby_ff <= (nxt_state == wfh_pkg::ST_STANDBY);
    end
  end

  assign link.fault_flag_pin_oe = fault_low_ff;
  assign link.fault_flag_pin_o = 1'b0;
  assign o_output_enable = oe_ff;
  assign o_sense_at_limit = limit_ff;
  assign o_status_overcurrent = st_oc_ff;
  assign o_status_thermal = st_ot_ff;
  assign o_in_standby = stby_ff;
endmodule : wfh_device

// ===== logic/wfh_ctrl.sv
// Purpose: controller end, wakes device and acknowledges flags
// Assumes: user requests are one-cycle pulses
// Notes: serial clear modelled as a one-cycle command pulse
`timescale 1ns/1ps
module wfh_ctrl (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_serial,
  input wire logic i_wake,
  input wire logic i_sleep,
  input wire logic i_ack,
  wfh_link_if.ctrl link,
  output logic o_fault_seen,
  output logic o_busy
);
  logic [1:0] s_flt_ff;
  logic sleep_pin_ff, clr_ff, busy_ff, seen_ff;
  logic [2:0] pulse_ff;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_flt_ff <= 2'h3;
    end else begin
      s_flt_ff <= {s_flt_ff[0], link.fault_flag_pin};
    end
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seen_ff <= 1'b0;
    end else begin
      seen_ff <= !s_flt_ff[1];
    end
  end
  // acknowledge only after flag seen low
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sleep_pin_ff <= 1'b0;
      clr_ff <= 1'b0;
      pulse_ff <= 3'h0;
      busy_ff <= 1'b0;
    end else begin
      clr_ff <= 1'b0;
      if (busy_ff) begin
        if (pulse_ff == 3'(wfh_pkg::PULSE_CYC - 1)) begin
          sleep_pin_ff <= 1'b1;
          busy_ff <= 1'b0;
        end
        pulse_ff <= pulse_ff + 3'h1;
      end else if (i_sleep) begin
        sleep_pin_ff <= 1'b0;
      end else if (i_wake) begin
        sleep_pin_ff <= 1'b1;
      end else if (i_ack && seen_ff && i_serial) begin
        clr_ff <= 1'b1;
      end else if (i_ack && seen_ff && sleep_pin_ff) begin
        sleep_pin_ff <= 1'b0;
        pulse_ff <= 3'h0;
        busy_ff <= 1'b1;
      end
    end
  end
  assign link.sleep_control_pin = sleep_pin_ff;
  assign link.clear_fault_command = clr_ff;
  assign o_fault_seen = seen_ff;
  assign o_busy = busy_ff;
endmodule : wfh_ctrl

// ===== tb/wfh_assertions.sv
// Purpose: checks on the wake and fault link
// Assumes: one clock, async low reset
// Notes: device pins watched beside the link
`timescale 1ns/1ps
module wfh_assertions (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic sleep_control_pin,
  input wire logic clear_fault_command,
  input wire logic fault_flag_pin_oe,
  input wire logic fault_flag_pin_o,
  input wire logic i_latch_mode,
  input wire logic i_overcurrent,
  input wire logic i_over_temp,
  input wire logic i_hs_short_gnd,
  input wire logic i_driver_enable,
  input wire logic o_output_enable,
  input wire logic o_sense_at_limit,
  input wire logic o_in_standby
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] oc_ff;
  // cycles of overcurrent while driving
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) oc_ff <= 8'h00;
    else oc_ff <= (i_overcurrent && o_output_enable) ? oc_ff + 8'h01 : 8'h00;
  end
  sequence trip_s;
    $fell(o_output_enable) && $past(i_overcurrent) && i_driver_enable;
  endsequence
  flag_level_a: assert property (fault_flag_pin_oe |-> !fault_flag_pin_o)
    else $error("flag driven high");
  wake_flag_a: assert property ($rose(sleep_control_pin) && !fault_flag_pin_oe &&
    !o_in_standby |-> ##[1:8] fault_flag_pin_oe) else $error("no flag after wake");
  ack_release_a: assert property ((clear_fault_command || $rose(sleep_control_pin)) &&
    fault_flag_pin_oe && i_latch_mode && !i_over_temp |-> ##[1:8] !fault_flag_pin_oe)
    else $error("flag kept after ack");
  oc_bound_a: assert property (oc_ff <= wfh_pkg::DEGLITCH_CYC + 8)
    else $error("overcurrent not tripped");
  oc_early_a: assert property (trip_s |-> $past(oc_ff) >= wfh_pkg::DEGLITCH_CYC - 4)
    else $error("trip before deglitch");
  oc_flag_a: assert property (trip_s |-> ##[0:4] fault_flag_pin_oe)
    else $error("no flag on trip");
  short_sense_a: assert property (trip_s ##0 i_hs_short_gnd |-> ##[0:4] o_sense_at_limit)
    else $error("sense not at limit");
  latch_hold_a: assert property ((i_latch_mode && fault_flag_pin_oe &&
    !clear_fault_command && sleep_control_pin)[*8] |-> !$rose(o_output_enable))
    else $error("output on before ack");
  standby_flag_a: assert property (o_in_standby |-> !fault_flag_pin_oe)
    else $error("flag low in standby");
  cover property ($rose(sleep_control_pin) && !fault_flag_pin_oe);
  cover property (trip_s);
  cover property (clear_fault_command);
endmodule : wfh_assertions

// ===== tb/tb.sv
// Purpose: runs both link ends against each other
// Assumes: 20 MHz clock, inputs driven 1 ns after edge
// Notes: overcurrent only flows while output is on
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [1:0] var_q = 2'h0;
  logic lat = 1'b1, ruv = 1'b0, luv = 1'b0, oc = 1'b0, hs = 1'b0, ot = 1'b0, drv = 1'b0;
  logic ser = 1'b0, wk = 1'b0, slp = 1'b0, ack = 1'b0, sh = 1'b0;
  logic oe, sense, st_oc, st_th, stby;
  int err_total = 0, n_tests = 0, cyc = 0;
  logic [31:0] rng = 32'h5AE628C5;
  wfh_link_if link ();
  wfh_device u_wfh_device (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_variant(var_q),
    .i_latch_mode(lat), .i_regulator_uv(ruv), .i_logic_supply_uv(luv), .i_overcurrent(oc),
    .i_hs_short_gnd(hs), .i_over_temp(ot), .i_driver_enable(drv), .link(link),
    .o_output_enable(oe), .o_sense_at_limit(sense), .o_status_overcurrent(st_oc),
    .o_status_thermal(st_th), .o_in_standby(stby));
  wfh_ctrl u_wfh_ctrl (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_serial(ser), .i_wake(wk),
    .i_sleep(slp), .i_ack(ack), .link(link), .o_fault_seen(), .o_busy());
  wfh_assertions u_wfh_assertions (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .sleep_control_pin(link.sleep_control_pin), .clear_fault_command(link.clear_fault_command),
    .fault_flag_pin_oe(link.fault_flag_pin_oe), .fault_flag_pin_o(link.fault_flag_pin_o),
    .i_latch_mode(lat), .i_overcurrent(oc), .i_over_temp(ot), .i_hs_short_gnd(hs),
    .i_driver_enable(drv), .o_output_enable(oe), .o_sense_at_limit(sense), .o_in_standby(stby));
  always #25 i_clock = ~i_clock;
  always @(posedge i_clock) #1 oc = sh & oe;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : step
  task automatic pulse(input int k);
    if (k == 0) wk = 1'b1; else if (k == 1) slp = 1'b1; else ack = 1'b1;
    step(1);
    wk = 1'b0;
    slp = 1'b0;
    ack = 1'b0;
  endtask : pulse
  task automatic wait_flag(input logic v);
    int i = 0;
    while (link.fault_flag_pin !== v && i < 40) begin
      step(1);
      i++;
    end
  endtask : wait_flag
  task automatic start(input int v, input logic l);
    var_q = v[1:0];
    ser = (v != 0);
    lat = l;
    i_rst_n = 1'b0;
    step(4);
    i_rst_n = 1'b1;
    step(10);
    if (v != 2) pulse(0);
    wait_flag(1'b0);
    `CHK("por_flag", 1'b0, link.fault_flag_pin)
    step(4);
    pulse(2);
    wait_flag(1'b1);
    step(2);
    `CHK("standby", 1'b1, stby)
  endtask : start
  task automatic finish_test();
    if (err_total == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  always @(posedge i_clock) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    for (int v = 0; v < 3; v++) begin
      start(v, 1'b1);
      if (v != 2) begin
        pulse(1);
        step(30);
        `CHK("sleep_stby", 1'b0, stby)
        pulse(0);
        wait_flag(1'b0);
        `CHK("wake_flag", 1'b0, link.fault_flag_pin)
        step(4);
        pulse(2);
        wait_flag(1'b1);
        `CHK("wake_ack", 1'b1, link.fault_flag_pin)
      end else begin
        ruv = 1'b1;
        step(10);
        `CHK("motor_uv", 1'b1, link.fault_flag_pin)
        ruv = 1'b0;
      end
      if (v == 2) luv = 1'b1; else ruv = 1'b1;
      step(6);
      luv = 1'b0;
      ruv = 1'b0;
      wait_flag(1'b0);
      `CHK("uv_flag", 1'b0, link.fault_flag_pin)
      step(4);
      pulse(2);
      wait_flag(1'b1);
      drv = 1'b1;
      hs = 1'b1;
      step(4);
      rng = xs(rng);
      sh = 1'b1;
      step(1 + rng[4:0]);
      sh = 1'b0;
      step(4);
      `CHK("glitch_oe", 1'b1, oe)
      sh = 1'b1;
      step(60);
      `CHK("trip_oe", 1'b0, oe)
      `CHK("trip_flag", 1'b0, link.fault_flag_pin)
      `CHK("sense", 1'b1, sense)
      pulse(2);
      step(60);
      `CHK("again_oe", 1'b0, oe)
      sh = 1'b0;
      if (ser) `CHK("st_held", 1'b1, st_oc)
      pulse(2);
      wait_flag(1'b1);
      step(4);
      `CHK("clear_oe", 1'b1, oe)
      if (ser) `CHK("st_clr", 1'b0, st_oc)
      drv = 1'b0;
      hs = 1'b0;
    end
    start(1, 1'b0);
    drv = 1'b1;
    step(4);
    ot = 1'b1;
    step(20);
    `CHK("hot_oe", 1'b0, oe)
    ot = 1'b0;
    step(20);
    `CHK("cool_oe", 1'b1, oe)
    `CHK("cool_flag", 1'b0, link.fault_flag_pin)
    `CHK("st_th", 1'b1, st_th)
    sh = 1'b1;
    step(300);
    `CHK("retry_wait", 1'b0, oe)
    `CHK("retry_flag", 1'b0, link.fault_flag_pin)
    finish_test();
  end
endmodule : tb
